// file: shared/format_unit_pkg.sv
// Package for the format-command decoder: opcodes, field positions,
// defaults, sense codes and reset values.
// Assumes a single 25 MHz clock domain; the files that use it need it compiled first.
`default_nettype none

package format_unit_pkg;

	// ----------------------------------------------------------------
	// Opcodes and command layout
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_FORMAT        = 8'h04;
	localparam logic [7:0] OP_REQUEST_SENSE = 8'h03;
	localparam logic [7:0] OP_INQUIRY       = 8'h12;
	localparam logic [2:0] FMT_LAST_IDX     = 3'h5;
	localparam int         CTL_NORMAL_AUTO_CONTINGENT_FLAG_BIT     = 2;
	localparam int         B1_PINFO_BIT     = 7;
	localparam int         B1_LONG_BIT      = 5;
	localparam int         B1_FOLLOWS_BIT   = 4;
	localparam int         B1_DISCARD_BIT   = 3;

	// ----------------------------------------------------------------
	// Field codes
	// ----------------------------------------------------------------
	localparam logic [2:0] DFMT_BLOCK       = 3'h0;
	localparam logic [2:0] DFMT_INDEX       = 3'h4;
	localparam logic [2:0] DFMT_PHYS        = 3'h5;
	localparam logic [2:0] PI_USAGE_MAX_ON  = 3'h1;

	typedef enum logic [1:0] {FAST_FORMAT_CODE_FULL, FAST_FORMAT_CODE_SIZE_ONLY, FAST_FORMAT_CODE_NO_INIT, FAST_FORMAT_CODE_RSVD} fast_format_code_t;

	// Options: {disable_primary, disable_certification, stop_on_list_error, init_pattern_flag, immediate}
	localparam logic [4:0] OPT_DEFAULT      = 5'h0c;

	// ----------------------------------------------------------------
	// Sense answers
	// ----------------------------------------------------------------
	localparam logic [3:0] KEY_GOOD         = 4'h0;
	localparam logic [3:0] KEY_NOT_READY    = 4'h2;
	localparam logic [3:0] KEY_MEDIUM_ERR   = 4'h3;
	localparam logic [3:0] KEY_ILLEGAL_REQ  = 4'h5;
	localparam logic [7:0] ASC_INVALID_CDB  = 8'h24;
	localparam logic [7:0] ASC_NOT_READY    = 8'h04;
	localparam logic [7:0] ASCQ_FMT_PROG    = 8'h04;
	localparam logic [7:0] ASC_FMT_FAILED   = 8'h31;
	localparam logic [7:0] ASCQ_NONE        = 8'h00;

	// ----------------------------------------------------------------
	// Block lengths
	// ----------------------------------------------------------------
	localparam logic [31:0] BLOCK_LEN_RESET = 32'h00000200;
	localparam logic [31:0] BLOCK_LEN_EMUL  = 32'h00000200;
	localparam logic [31:0] BLOCK_LEN_PHYS  = 32'h00001000;

endpackage

`default_nettype wire

// file: logic/format_unit_cdb_decoder.sv
// Decoder for the format command: collects the command bytes, checks
// them, applies defaults or the parameter list header, and runs the
// format handshake with the medium engine.
// Assumes all inputs are synchronous to clk; the medium engine answers
// each fmt_start with exactly one fmt_complete pulse.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Control flags come from the last command byte, whatever the length.
// - Normal auto-contingent flag must be zero; no allegiance is ever set.
// - Multi-byte fields arrive most significant byte first.
// - Parameter-list-follows one: a data-out header follows the command.
// - Without a parameter list, fixed default options apply.
// - Discard flag one: drop grown list, supplied list becomes grown list.
// - Discard flag zero: keep grown list, merge supplied list into it.
// - Defect formats 100b and 101b accepted; 000b unsupported.
// - No parameter list with nonzero defect format: illegal request.
// - Format uses latest mode-select length; saved only after success.
// - Without mode-select since reset, previous format length is reused.
// - Protection info from format flag and header usage value.
// - Fast code 00b: defect management and full medium initialisation.
// - Fast code 01b: compatible block size change only, else illegal.
// - Fast code 10b: defect management without initialising medium.
// - While formatting, all but sense and inquiry get check condition.
// - Accepted format sets unit attention for all other initiators.
module format_unit_cdb_decoder
(
	input  wire logic        clk,               // 25 MHz clock
	input  wire logic        reset_n,           // Asynchronous reset, active low
	input  wire logic        cdb_valid,         // Command byte present
	input  wire logic [7:0]  cdb_byte,          // Command byte
	input  wire logic        cdb_last,          // Byte is the control byte
	input  wire logic [3:0]  cdb_initiator,     // Issuing initiator id
	output logic             cdb_ready,         // Command byte accepted
	input  wire logic        ms_len_valid,      // Mode-select block length byte present
	input  wire logic [7:0]  ms_len_byte,       // Length byte, most significant first
	output logic             hdr_req,           // Waiting for parameter list header
	input  wire logic        hdr_valid,         // Header bytes 0 and 1 present
	input  wire logic [7:0]  hdr_byte0,         // Header byte 0
	input  wire logic [7:0]  hdr_byte1,         // Header byte 1
	output logic             resp_valid,        // Status answer pulse
	output logic             resp_check,        // Answer is check condition
	output logic [3:0]       resp_sense_key,    // Sense key
	output logic [7:0]       resp_asc,          // Additional sense code
	output logic [7:0]       resp_ascq,         // Additional sense qualifier
	output logic             pass_valid,        // Command handed to other decoders
	output logic [7:0]       pass_opcode,       // Its opcode
	output logic             fmt_start,         // Start pulse to medium engine
	output logic             fmt_active,        // Format in progress
	output logic             disable_primary,   // Option latched at start
	output logic             disable_certification, // Option latched at start
	output logic             stop_on_list_error, // Option latched at start
	output logic             init_pattern_flag, // Option latched at start
	output logic             discard_grown_list_flag, // Replace rather than merge grown list
	output logic             defect_mgmt,       // Run defect management
	output logic             init_medium,       // Write the whole medium
	output logic             size_only,         // Change block size only
	output logic             pi_enable,         // Protection information on
	output logic [31:0]      fmt_block_len,     // Block length to format with
	input  wire logic        fmt_complete,      // Engine finished pulse
	input  wire logic        fmt_good,          // Finish was successful
	output logic [31:0]      saved_block_len,   // Length of last good format
	output logic             degraded,          // Last format failed
	output logic             ua_set,            // Unit attention pulse
	output logic [3:0]       ua_except_id       // Initiator spared from it
);

	// ------------------------------------------------------------------
	// State and storage
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_FORMAT} state_t;

	state_t      state_reg;
	state_t      state_next;
	logic [7:0]  cdb_mem [0:4];
	logic [2:0]  idx_reg;
	logic [31:0] ms_len_reg;
	logic        ms_seen_reg;
	logic [4:0]  opt_reg;
	logic        pinfo_reg;
	logic        discard_reg;
	logic [1:0]  fast_format_code_reg;
	logic        immed_reg;

	// ------------------------------------------------------------------
	// Decode of the finished command
	// ------------------------------------------------------------------
	wire         take       = cdb_valid && cdb_ready;
	wire         cmd_end    = take && cdb_last;
	wire [7:0]   opcode     = (idx_reg == 3'h0) ? cdb_byte : cdb_mem[0];
	wire [7:0]   flags      = cdb_mem[1];
	wire         normal_auto_contingent_flag       = cdb_byte[format_unit_pkg::CTL_NORMAL_AUTO_CONTINGENT_FLAG_BIT];
	wire         is_format  = opcode == format_unit_pkg::OP_FORMAT;
	wire         follows    = flags[format_unit_pkg::B1_FOLLOWS_BIT];
	wire [2:0]   dfmt       = flags[2:0];
	wire [1:0]   fast_format_code       = cdb_mem[4][1:0];
	wire         pinfo      = flags[format_unit_pkg::B1_PINFO_BIT];
	wire         dfmt_ok    = (dfmt == format_unit_pkg::DFMT_INDEX) ||
	                          (dfmt == format_unit_pkg::DFMT_PHYS);
	wire         dfmt_bad   = follows ? !dfmt_ok
	                                  : (dfmt != format_unit_pkg::DFMT_BLOCK);
	wire [31:0]  target_len = ms_seen_reg ? ms_len_reg : saved_block_len;
	wire         cur_phys   = (saved_block_len == format_unit_pkg::BLOCK_LEN_EMUL) ||
	                          (saved_block_len == format_unit_pkg::BLOCK_LEN_PHYS);
	wire         tgt_phys   = (target_len == format_unit_pkg::BLOCK_LEN_EMUL) ||
	                          (target_len == format_unit_pkg::BLOCK_LEN_PHYS);
	// Protection information changes the physical layout, so it never counts as compatible
	wire         compatible = cur_phys && tgt_phys && !pinfo;
	wire         fast_format_code_bad   = (fast_format_code == 2'(format_unit_pkg::FAST_FORMAT_CODE_RSVD)) ||
	                          ((fast_format_code == 2'(format_unit_pkg::FAST_FORMAT_CODE_SIZE_ONLY)) && !compatible);
	wire         fmt_bad    = (idx_reg != format_unit_pkg::FMT_LAST_IDX) || normal_auto_contingent_flag ||
	                          flags[format_unit_pkg::B1_LONG_BIT] || dfmt_bad || fast_format_code_bad;
	wire         busy_cmd   = (state_reg == ST_FORMAT);
	wire         exempt     = (opcode == format_unit_pkg::OP_REQUEST_SENSE) ||
	                          (opcode == format_unit_pkg::OP_INQUIRY);
	wire         reject     = cmd_end && busy_cmd && !exempt;
	wire         pass       = cmd_end && (busy_cmd ? exempt : !is_format);
	wire         illegal    = cmd_end && !busy_cmd && is_format && fmt_bad;
	wire         accept     = cmd_end && !busy_cmd && is_format && !fmt_bad;
	wire         go_now     = accept && !follows;
	wire         go_hdr     = (state_reg == ST_HDR) && hdr_valid;
	wire         start      = go_now || go_hdr;
	wire         immed_next = go_hdr && hdr_byte1[1];
	wire [4:0]   opt_next   = go_hdr ? {hdr_byte1[6:3], hdr_byte1[1]} : format_unit_pkg::OPT_DEFAULT;
	wire [2:0]   pi_usage   = go_hdr ? hdr_byte0[2:0] : 3'h0;
	wire         finish     = (state_reg == ST_FORMAT) && fmt_complete;
	wire         fmt_answer = finish && !immed_reg;

	// Stall the command port while a header is owed or while a finish would collide with a reject
	assign cdb_ready = (state_reg != ST_HDR) && !finish;
	assign hdr_req   = (state_reg == ST_HDR);
	assign fmt_active = (state_reg == ST_FORMAT);
	assign disable_primary       = opt_reg[4];
	assign disable_certification = opt_reg[3];
	assign stop_on_list_error    = opt_reg[2];
	assign init_pattern_flag     = opt_reg[1];
	assign discard_grown_list_flag = discard_reg;
	assign defect_mgmt = (fast_format_code_reg == 2'(format_unit_pkg::FAST_FORMAT_CODE_FULL)) ||
	                     (fast_format_code_reg == 2'(format_unit_pkg::FAST_FORMAT_CODE_NO_INIT));
	assign init_medium = (fast_format_code_reg == 2'(format_unit_pkg::FAST_FORMAT_CODE_FULL));
	assign size_only   = (fast_format_code_reg == 2'(format_unit_pkg::FAST_FORMAT_CODE_SIZE_ONLY));

	// ------------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:   if (go_now) state_next = ST_FORMAT;
			           else if (accept) state_next = ST_HDR;
			ST_HDR:    if (hdr_valid) state_next = ST_FORMAT;
			ST_FORMAT: if (fmt_complete) state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------------
	// Command byte capture
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			idx_reg <= 3'h0;
		else if (cmd_end)
			idx_reg <= 3'h0;
		else if (take && idx_reg != 3'h7)
			idx_reg <= idx_reg + 3'h1;
	end

	always_ff @(posedge clk)
	begin
		if (take && idx_reg < 3'h5)
			cdb_mem[idx_reg] <= cdb_byte;
	end

	// ------------------------------------------------------------------
	// Block length: shifted in most significant byte first
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ms_len_reg  <= 32'h00000000;
			ms_seen_reg <= 1'b0;
		end
		else if (ms_len_valid)
		begin
			ms_len_reg  <= {ms_len_reg[23:0], ms_len_byte};
			ms_seen_reg <= 1'b1;
		end
	end

	// A failed format leaves the stored length alone so a retry starts from the same point
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			saved_block_len <= format_unit_pkg::BLOCK_LEN_RESET;
		else if (finish && fmt_good)
			saved_block_len <= fmt_block_len;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			degraded <= 1'b0;
		else if (finish)
			degraded <= !fmt_good;
	end

	// ------------------------------------------------------------------
	// Options latched at acceptance and at start
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pinfo_reg   <= 1'b0;
			discard_reg <= 1'b0;
			fast_format_code_reg    <= 2'h0;
			fmt_block_len <= format_unit_pkg::BLOCK_LEN_RESET;
		end
		else if (accept)
		begin
			pinfo_reg   <= pinfo;
			discard_reg <= flags[format_unit_pkg::B1_DISCARD_BIT];
			fast_format_code_reg    <= fast_format_code;
			fmt_block_len <= target_len;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			opt_reg   <= format_unit_pkg::OPT_DEFAULT;
			immed_reg <= 1'b0;
			pi_enable <= 1'b0;
		end
		else if (start)
		begin
			opt_reg   <= opt_next;
			immed_reg <= immed_next;
			pi_enable <= (go_now ? pinfo : pinfo_reg) &&
			             (pi_usage <= format_unit_pkg::PI_USAGE_MAX_ON);
		end
	end

	// ------------------------------------------------------------------
	// Answers and pulses
	// ------------------------------------------------------------------
	wire         ans_now   = reject || illegal || fmt_answer || (start && immed_next);
	wire         ans_check = reject || illegal || (fmt_answer && !fmt_good);
	wire [3:0]   ans_key   = reject  ? format_unit_pkg::KEY_NOT_READY :
	                         illegal ? format_unit_pkg::KEY_ILLEGAL_REQ :
	                         ans_check ? format_unit_pkg::KEY_MEDIUM_ERR : format_unit_pkg::KEY_GOOD;
	wire [7:0]   ans_asc   = reject  ? format_unit_pkg::ASC_NOT_READY :
	                         illegal ? format_unit_pkg::ASC_INVALID_CDB :
	                         ans_check ? format_unit_pkg::ASC_FMT_FAILED : format_unit_pkg::ASCQ_NONE;
	wire [7:0]   ans_ascq  = reject ? format_unit_pkg::ASCQ_FMT_PROG : format_unit_pkg::ASCQ_NONE;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			resp_valid     <= 1'b0;
			resp_check     <= 1'b0;
			resp_sense_key <= 4'h0;
			resp_asc       <= 8'h00;
			resp_ascq      <= 8'h00;
		end
		else
		begin
			resp_valid     <= ans_now;
			resp_check     <= ans_now && ans_check;
			resp_sense_key <= ans_now ? ans_key : 4'h0;
			resp_asc       <= ans_now ? ans_asc : 8'h00;
			resp_ascq      <= ans_now ? ans_ascq : 8'h00;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pass_valid   <= 1'b0;
			pass_opcode  <= 8'h00;
			fmt_start    <= 1'b0;
			ua_set       <= 1'b0;
			ua_except_id <= 4'h0;
		end
		else
		begin
			pass_valid <= pass;
			fmt_start  <= start;
			ua_set     <= accept;
			if (pass)
				pass_opcode <= opcode;
			if (accept)
				ua_except_id <= cdb_initiator;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	busy_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
		reject |=> resp_valid && resp_check && resp_sense_key == format_unit_pkg::KEY_NOT_READY)
		else $error("busy command not rejected");
	exempt_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cmd_end && busy_cmd && exempt) |=> pass_valid && !resp_valid)
		else $error("sense or inquiry not passed while busy");
	normal_auto_contingent_flag_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cmd_end && !busy_cmd && is_format && normal_auto_contingent_flag) |=> resp_check && !fmt_start ##1 !fmt_active)
		else $error("auto-contingent flag accepted");
	dfmt_nolist_a: assert property (@(posedge clk) disable iff (!reset_n)
		(cmd_end && !busy_cmd && is_format && !follows && dfmt != 3'h0)
		|=> resp_check && resp_asc == format_unit_pkg::ASC_INVALID_CDB)
		else $error("defect format without list accepted");
	default_opts_a: assert property (@(posedge clk) disable iff (!reset_n)
		go_now |=> fmt_start && {disable_primary, disable_certification, stop_on_list_error,
		init_pattern_flag} == 4'h6)
		else $error("default options wrong");
	header_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && follows) |=> hdr_req && !cdb_ready && !fmt_start)
		else $error("header not awaited");
	len_saved_a: assert property (@(posedge clk) disable iff (!reset_n)
		(finish && !fmt_good) |=> $stable(saved_block_len) && degraded)
		else $error("length saved after failed format");
	len_reuse_a: assert property (@(posedge clk) disable iff (!reset_n)
		(accept && !ms_seen_reg) |=> fmt_block_len == $past(saved_block_len))
		else $error("saved length not reused");
	unit_attn_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept |=> ua_set && ua_except_id == $past(cdb_initiator))
		else $error("unit attention missing");
	size_only_a: assert property (@(posedge clk) disable iff (!reset_n)
		(fmt_active && size_only) |-> !init_medium && !defect_mgmt)
		else $error("size-only mode touches medium");

endmodule

`default_nettype wire

// file: test/format_engine_model.sv
// Behavioural medium engine: answers each start pulse with one finish pulse.
// Assumes start pulses arrive one cycle long, never while a job is pending.
`timescale 1ns/1ps
`default_nettype none

module format_engine_model
(
	input  wire logic       clk,          // 25 MHz clock
	input  wire logic       reset_n,      // Asynchronous reset, active low
	input  wire logic       fmt_start,    // Job start pulse
	input  wire logic [7:0] delay,        // Countdown length; the finish pulse comes delay + 1 cycles after the start pulse is sampled
	input  wire logic       good,         // Outcome to report
	output logic            fmt_complete, // Finish pulse
	output logic            fmt_good      // Outcome, valid with finish only
);
	logic [7:0] cnt_reg;
	logic       busy_reg;

	// Outcome line toggles every cycle outside the finish pulse so a stale value is never trusted
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_reg <= 8'h00;
			busy_reg <= 1'b0;
			fmt_complete <= 1'b0;
			fmt_good <= 1'b0;
		end
		else
		begin
			fmt_complete <= 1'b0;
			fmt_good <= ~fmt_good;
			if (fmt_start)
			begin
				busy_reg <= 1'b1;
				cnt_reg <= delay;
			end
			else if (busy_reg && cnt_reg == 8'h00)
			begin
				busy_reg <= 1'b0;
				fmt_complete <= 1'b1;
				fmt_good <= good;
			end
			else if (busy_reg)
				cnt_reg <= cnt_reg - 8'h01;
		end
	end
endmodule

`default_nettype wire

// file: test/format_unit_cdb_decoder_bench.sv
// Self-checking bench for the format-command decoder.
// Assumes the package is compiled first; the engine model stands behind it.
`timescale 1ns/1ps
`default_nettype none

module format_unit_cdb_decoder_bench;
	typedef struct packed {logic [7:0] b1; logic [7:0] b4; logic [7:0] ctl; logic acc; logic dm; logic im;} row_t;
	logic clk = 1'b0, reset_n = 1'b0, cdb_valid = 1'b0, cdb_last = 1'b0, ms_len_valid = 1'b0, hdr_valid = 1'b0;
	logic [7:0] cdb_byte = 8'h00, ms_len_byte = 8'h00, hdr_byte0 = 8'h00, hdr_byte1 = 8'h00, delay = 8'h03;
	logic [3:0] cdb_initiator = 4'h0, resp_sense_key, ua_except_id;
	logic good = 1'b1, cdb_ready, hdr_req, resp_valid, resp_check, pass_valid, fmt_start, fmt_active, ua_set;
	logic disable_primary, disable_certification, stop_on_list_error, init_pattern_flag, discard_grown_list_flag;
	logic defect_mgmt, init_medium, size_only, pi_enable, fmt_complete, fmt_good, degraded;
	logic [7:0] resp_asc, resp_ascq, pass_opcode;
	logic [31:0] fmt_block_len, saved_block_len;
	int err_count = 0, n_checks = 0, i;
	row_t rows [8];

	format_unit_cdb_decoder dut_u (.clk, .reset_n, .cdb_valid, .cdb_byte, .cdb_last, .cdb_initiator, .cdb_ready,
		.ms_len_valid, .ms_len_byte, .hdr_req, .hdr_valid, .hdr_byte0, .hdr_byte1, .resp_valid, .resp_check,
		.resp_sense_key, .resp_asc, .resp_ascq, .pass_valid, .pass_opcode, .fmt_start, .fmt_active,
		.disable_primary, .disable_certification, .stop_on_list_error, .init_pattern_flag,
		.discard_grown_list_flag, .defect_mgmt, .init_medium, .size_only, .pi_enable, .fmt_block_len,
		.fmt_complete, .fmt_good, .saved_block_len, .degraded, .ua_set, .ua_except_id);
	format_engine_model eng_u (.clk, .reset_n, .fmt_start, .delay, .good, .fmt_complete, .fmt_good);

	initial
	begin
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Bytes other than opcode, flags, fast code and control are zero
	task automatic cmd(input logic [7:0] op, b1, b4, ctl, input int n, input logic [3:0] id);
		int k;
		@(posedge clk);
		for (int j = 0; j < n; j++)
		begin
			cdb_valid <= 1'b1;
			cdb_byte <= (j == n - 1) ? ctl : (j == 0) ? op : (j == 1) ? b1 : (j == 4) ? b4 : 8'h00;
			cdb_last <= (j == n - 1);
			cdb_initiator <= id;
			for (k = 0; k < 50; k++)
			begin
				@(negedge clk);
				if (cdb_ready === 1'b1)
					break;
			end
			if (k == 50)
			begin
				err_count++;
				give_verdict();
			end
			@(posedge clk);
		end
		cdb_valid <= 1'b0;
		cdb_last <= 1'b0;
	endtask

	// Waits for any answer; a long silence ends the run
	task automatic wt();
		int k;
		for (k = 0; k < 200; k++)
		begin
			@(negedge clk);
			if (resp_valid === 1'b1 || fmt_start === 1'b1 || pass_valid === 1'b1 || hdr_req === 1'b1)
				break;
		end
		if (k == 200)
		begin
			err_count++;
			give_verdict();
		end
	endtask

	task automatic resp(input logic c, input logic [3:0] key, input logic [7:0] asc, ascq);
		chk(resp_valid, 1'b1);
		chk({resp_check, resp_sense_key, resp_asc, resp_ascq}, {c, key, asc, ascq});
	endtask

	task automatic started(input logic dm, im, so, input logic [3:0] id);
		chk({fmt_start, fmt_active, ua_set}, 3'h7);
		chk(ua_except_id, id);
		chk({defect_mgmt, init_medium, size_only}, {dm, im, so});
	endtask

	task automatic done(input logic ok);
		wt();
		resp(!ok, ok ? 4'h0 : 4'h3, ok ? 8'h00 : 8'h31, 8'h00);
		chk(fmt_active, 1'b0);
	endtask

	task automatic ms(input logic [31:0] v);
		for (int b = 0; b < 4; b++)
		begin
			@(posedge clk);
			ms_len_valid <= 1'b1;
			ms_len_byte <= v[31 - 8 * b -: 8];
		end
		@(posedge clk);
		ms_len_valid <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		rows = '{'{8'h00, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1}, '{8'h00, 8'h02, 8'h00, 1'b1, 1'b1, 1'b0},
			'{8'h00, 8'h03, 8'h00, 1'b0, 1'b0, 1'b0}, '{8'h04, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
			'{8'h10, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0}, '{8'h00, 8'h00, 8'h04, 1'b0, 1'b0, 1'b0},
			'{8'h20, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0}, '{8'h80, 8'h01, 8'h00, 1'b0, 1'b0, 1'b0}};
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		chk({cdb_ready, hdr_req, fmt_active, degraded, disable_certification, stop_on_list_error}, 6'h23);
		chk(saved_block_len, 32'h00000200);
		for (i = 0; i < 8; i++)
		begin
			cmd(format_unit_pkg::OP_FORMAT, rows[i].b1, rows[i].b4, rows[i].ctl, 6, i[3:0]);
			wt();
			if (rows[i].acc)
			begin
				started(rows[i].dm, rows[i].im, 1'b0, i[3:0]);
				chk({disable_primary, disable_certification, stop_on_list_error, init_pattern_flag}, 4'h6);
				chk({discard_grown_list_flag, fmt_block_len}, 33'h000000200);
				done(1'b1);
			end
			else
				resp(1'b1, 4'h5, 8'h24, 8'h00);
		end
		cmd(8'h28, 8'h00, 8'h00, 8'h00, 10, 4'h0);
		wt();
		chk({pass_valid, pass_opcode}, 9'h128);
		cmd(format_unit_pkg::OP_FORMAT, 8'h00, 8'h00, 8'h00, 10, 4'h0);
		wt();
		resp(1'b1, 4'h5, 8'h24, 8'h00);
		cmd(format_unit_pkg::OP_FORMAT, 8'h9d, 8'h00, 8'h00, 6, 4'h3);
		wt();
		chk(hdr_req, 1'b1);
		chk({ua_set, ua_except_id}, 5'h13);
		@(posedge clk);
		hdr_valid <= 1'b1;
		hdr_byte0 <= 8'h01;
		hdr_byte1 <= 8'h48;
		@(posedge clk);
		hdr_valid <= 1'b0;
		wt();
		chk({fmt_start, fmt_active, ua_set, defect_mgmt, init_medium, size_only}, 6'h36);
		chk({disable_primary, disable_certification, stop_on_list_error, init_pattern_flag}, 4'h9);
		chk({pi_enable, discard_grown_list_flag}, 2'h3);
		done(1'b1);
		ms(32'h00001000);
		delay <= 8'h50;
		good <= 1'b0;
		cmd(format_unit_pkg::OP_FORMAT, 8'h00, 8'h01, 8'h00, 6, 4'h5);
		wt();
		started(1'b0, 1'b0, 1'b1, 4'h5);
		chk(fmt_block_len, 32'h00001000);
		cmd(8'h08, 8'h00, 8'h00, 8'h00, 6, 4'h2);
		wt();
		resp(1'b1, 4'h2, 8'h04, 8'h04);
		cmd(8'h03, 8'h00, 8'h00, 8'h00, 6, 4'h2);
		wt();
		chk({pass_valid, pass_opcode}, 9'h103);
		cmd(8'h12, 8'h00, 8'h00, 8'h00, 6, 4'h2);
		wt();
		chk({pass_valid, pass_opcode}, 9'h112);
		done(1'b0);
		chk({degraded, saved_block_len}, 33'h100000200);
		delay <= 8'h03;
		good <= 1'b1;
		cmd(format_unit_pkg::OP_FORMAT, 8'h00, 8'h00, 8'h00, 6, 4'h1);
		wt();
		started(1'b1, 1'b1, 1'b0, 4'h1);
		done(1'b1);
		chk({degraded, saved_block_len}, 33'h000001000);
		// Immediate header: good status at start, none at finish
		cmd(format_unit_pkg::OP_FORMAT, 8'h9c, 8'h00, 8'h00, 6, 4'h6);
		wt();
		chk(hdr_req, 1'b1);
		@(posedge clk);
		hdr_valid <= 1'b1;
		hdr_byte0 <= 8'h02;
		hdr_byte1 <= 8'h12;
		@(posedge clk);
		hdr_valid <= 1'b0;
		wt();
		resp(1'b0, 4'h0, 8'h00, 8'h00);
		chk({fmt_start, pi_enable}, 2'h2);
		chk({disable_primary, disable_certification, stop_on_list_error, init_pattern_flag}, 4'h2);
		for (i = 0; i < 10; i++)
		begin
			@(negedge clk);
			if (resp_valid !== 1'b0)
				chk(resp_valid, 1'b0);
		end
		chk({fmt_active, degraded, saved_block_len}, 34'h000001000);
		give_verdict();
	end
endmodule

`default_nettype wire
